// File: timer_pair_pkg.sv
package timer_pair_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] RUN_CTRL_IDX     = 6'h0E;
  localparam logic [5:0] CTRL0_IDX        = 6'h0F;
  localparam logic [5:0] RELOAD0_HI_IDX   = 6'h10;
  localparam logic [5:0] RELOAD0_LO_IDX   = 6'h11;
  localparam logic [5:0] COUNT0_HI_IDX    = 6'h12;
  localparam logic [5:0] COUNT0_LO_IDX    = 6'h13;
  localparam logic [5:0] CTRL1_IDX        = 6'h14;
  localparam logic [5:0] RELOAD1_HI_IDX   = 6'h15;
  localparam logic [5:0] RELOAD1_LO_IDX   = 6'h16;
  localparam logic [5:0] COUNT1_HI_IDX    = 6'h17;
  localparam logic [5:0] COUNT1_LO_IDX    = 6'h18;
  localparam logic [5:0] FLAG_IDX         = 6'h1A;

  // Timer control field layout
  localparam int HALT_ON_RX_BIT = 7;
  localparam int START_SRC_HI   = 5;
  localparam int START_SRC_LO   = 4;
  localparam int RELOAD_ZERO_BIT = 3;
  localparam int TICK_SRC_HI    = 1;
  localparam int TICK_SRC_LO    = 0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hBB;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] RELOAD_RESET    = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;

  // Run-control layout: running bits above, write mask below
  localparam int RUN_FIELD_LO = 4;

  // Start source codes
  localparam logic [1:0] START_NONE     = 2'h0;
  localparam logic [1:0] START_TX_END   = 2'h1;
  localparam logic [1:0] START_LFO_NOUF = 2'h2;
  localparam logic [1:0] START_LFO_UF   = 2'h3;

  // Tick source codes
  localparam logic [1:0] TICK_FAST    = 2'h0;
  localparam logic [1:0] TICK_SLOW    = 2'h1;
  localparam logic [1:0] TICK_CASC_A  = 2'h2;
  localparam logic [1:0] TICK_CASC_B  = 2'h3;

  // Tick generation
  localparam int SYS_CLK_HZ   = 100_000_000;
  localparam int FAST_TICK_HZ = 13_560_000;
  localparam int SLOW_TICK_HZ = 211_875;
  localparam int SLOW_DIV     = FAST_TICK_HZ / SLOW_TICK_HZ;
  localparam logic [27:0] PHASE_STEP  = 28'(FAST_TICK_HZ);
  localparam logic [27:0] PHASE_LIMIT = 28'(SYS_CLK_HZ);
  localparam logic [5:0]  SLOW_LAST   = 6'(SLOW_DIV - 1);

endpackage

// File: reload_countdown_timer_pair.sv
// Operation
// - Reload value is high and low byte
// - Start event copies reload into counter
// - Reload writes wait for next start
// - First timer count readable as two bytes
// - Halt bit stops timer after four bits
// - Halt bit ignored in oscillator trimming modes
// - Source 00 never starts automatically
// - Source 01 starts at transmission end
// - Source 10 trims oscillator, no underflow
// - Source 11 trims oscillator with underflow
// - Reload on zero restarts the countdown
// - Without reload, count to zero and stop
// - Underflow sets the underflow flag
// - Tick source 00 is 13.56 MHz
// - Tick source 01 is 211.875 kHz
// - Second timer ticks on first underflow
// - Second timer ticks on third underflow
// - Run bit 5 changes only with bit 1
// - Low nibble masks upper running bits
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module reload_countdown_timer_pair
  import timer_pair_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Transceiver events, one-cycle pulses
  input  wire logic        tx_done,
  input  wire logic        rx_first_bits,
  input  wire logic        lfo_rise,
  input  wire logic        third_underflow,
  // Timer status
  output logic [1:0]       second_timer_underflow_flag,
  output logic [1:0]       timer_running
);

  logic [7:0]  ctrl_reg     [2];
  logic [7:0]  ctrl_next    [2];
  logic [7:0]  rel_hi_reg   [2];
  logic [7:0]  rel_hi_next  [2];
  logic [7:0]  rel_lo_reg   [2];
  logic [7:0]  rel_lo_next  [2];
  logic [15:0] count_reg    [2];
  logic [15:0] count_next   [2];
  logic [1:0]  run_reg;
  logic [1:0]  run_next;
  logic [1:0]  uf_reg;
  logic [1:0]  uf_next;
  logic [1:0]  flag_reg;
  logic [1:0]  flag_next;
  logic [27:0] phase_reg;
  logic [27:0] phase_next;
  logic [5:0]  slow_cnt_reg;
  logic [5:0]  slow_cnt_next;
  logic        fast_tick;
  logic        slow_tick;
  logic [31:0] prdata_reg;
  logic [31:0] rdata_mux;
  logic        err_reg;
  logic [5:0]  idx;
  logic        aligned;
  logic        mapped;
  logic        access;
  logic        wr;
  logic        setup;
  logic [7:0]  wbyte;
  logic [1:0]  tick;
  logic [1:0]  sw_start;
  logic [1:0]  sw_stop;

  function automatic logic pick_tick(input logic [1:0] sel,
                                     input logic fast,
                                     input logic slow,
                                     input logic casc_a,
                                     input logic casc_b);
    logic r;
    r = fast;
    unique case (sel)
      TICK_FAST:   r = fast;
      TICK_SLOW:   r = slow;
      TICK_CASC_A: r = casc_a;
      TICK_CASC_B: r = casc_b;
    endcase
    return r;
  endfunction

  function automatic logic is_trim(input logic [7:0] ctl);
    return ctl[START_SRC_HI];
  endfunction

  // Bus decode
  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped  = aligned && (idx == RUN_CTRL_IDX || idx == FLAG_IDX ||
                   (idx >= CTRL0_IDX && idx <= COUNT1_LO_IDX));
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr      = access && pwrite && mapped;
  assign wbyte   = pwdata[7:0];
  assign pready  = access;
  assign pslverr = access && err_reg;
  assign prdata  = prdata_reg;
  assign second_timer_underflow_flag = flag_reg;
  assign timer_running = run_reg;

  // Read mux; reserved and unused bits read as zero
  always_comb begin
    rdata_mux = 32'h0000_0000;
    unique case (idx)
      RUN_CTRL_IDX:   rdata_mux[7:0] = {2'h0, run_reg, 4'h0};
      CTRL0_IDX:      rdata_mux[7:0] = ctrl_reg[0] & CTRL_WRITE_MASK;
      RELOAD0_HI_IDX: rdata_mux[7:0] = rel_hi_reg[0];
      RELOAD0_LO_IDX: rdata_mux[7:0] = rel_lo_reg[0];
      COUNT0_HI_IDX:  rdata_mux[7:0] = count_reg[0][15:8];
      COUNT0_LO_IDX:  rdata_mux[7:0] = count_reg[0][7:0];
      CTRL1_IDX:      rdata_mux[7:0] = ctrl_reg[1] & CTRL_WRITE_MASK;
      RELOAD1_HI_IDX: rdata_mux[7:0] = rel_hi_reg[1];
      RELOAD1_LO_IDX: rdata_mux[7:0] = rel_lo_reg[1];
      COUNT1_HI_IDX:  rdata_mux[7:0] = count_reg[1][15:8];
      COUNT1_LO_IDX:  rdata_mux[7:0] = count_reg[1][7:0];
      FLAG_IDX:       rdata_mux[7:0] = {6'h00, flag_reg};
      default:        rdata_mux = 32'h0000_0000;
    endcase
    if (!aligned) begin
      rdata_mux = 32'h0000_0000;
    end
  end

  // Fractional divider gives an average 13.56 MHz tick from pclk
  always_comb begin
    fast_tick     = (phase_reg + PHASE_STEP) >= PHASE_LIMIT;
    phase_next    = fast_tick ? phase_reg + PHASE_STEP - PHASE_LIMIT
                              : phase_reg + PHASE_STEP;
    slow_tick     = fast_tick && (slow_cnt_reg == SLOW_LAST);
    slow_cnt_next = slow_cnt_reg;
    if (fast_tick) begin
      slow_cnt_next = slow_tick ? 6'h00 : slow_cnt_reg + 6'h01;
    end
  end

  // Cascades use registered underflows so the two timers never loop
  assign tick[0] = pick_tick(ctrl_reg[0][TICK_SRC_HI:TICK_SRC_LO],
                             fast_tick, slow_tick, third_underflow,
                             uf_reg[1]);
  assign tick[1] = pick_tick(ctrl_reg[1][TICK_SRC_HI:TICK_SRC_LO],
                             fast_tick, slow_tick, uf_reg[0],
                             third_underflow);

  // Software writes change running bits only where the low nibble mask is set
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sw_start[i] = wr && idx == RUN_CTRL_IDX && wbyte[i]
                    && wbyte[RUN_FIELD_LO + i];
      sw_stop[i]  = wr && idx == RUN_CTRL_IDX && wbyte[i]
                    && !wbyte[RUN_FIELD_LO + i];
    end
  end

  // Register writes
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ctrl_next[i]   = ctrl_reg[i];
      rel_hi_next[i] = rel_hi_reg[i];
      rel_lo_next[i] = rel_lo_reg[i];
    end
    if (wr) begin
      unique case (idx)
        CTRL0_IDX:      ctrl_next[0]   = wbyte & CTRL_WRITE_MASK;
        CTRL1_IDX:      ctrl_next[1]   = wbyte & CTRL_WRITE_MASK;
        RELOAD0_HI_IDX: rel_hi_next[0] = wbyte;
        RELOAD0_LO_IDX: rel_lo_next[0] = wbyte;
        RELOAD1_HI_IDX: rel_hi_next[1] = wbyte;
        RELOAD1_LO_IDX: rel_lo_next[1] = wbyte;
        default: ;
      endcase
    end
  end

  // Counting engine for both timers
  always_comb begin
    logic [1:0]  src;
    logic        start_ev;
    logic        stop_ev;
    logic        hit_zero;
    logic [15:0] reload;
    src      = 2'h0;
    start_ev = 1'b0;
    stop_ev  = 1'b0;
    hit_zero = 1'b0;
    reload   = 16'h0000;
    run_next = run_reg;
    uf_next  = 2'h0;
    for (int i = 0; i < 2; i++) begin
      count_next[i] = count_reg[i];
      src      = ctrl_reg[i][START_SRC_HI:START_SRC_LO];
      reload   = {rel_hi_reg[i], rel_lo_reg[i]};
      // Source 00 has no automatic start term at all
      start_ev = sw_start[i]
                 || (src == START_TX_END && tx_done)
                 || (is_trim(ctrl_reg[i]) && lfo_rise && !run_reg[i]);
      stop_ev  = sw_stop[i]
                 || (is_trim(ctrl_reg[i]) && lfo_rise && run_reg[i])
                 || (ctrl_reg[i][HALT_ON_RX_BIT] && rx_first_bits
                     && !is_trim(ctrl_reg[i]));
      hit_zero = count_reg[i] <= 16'h0001;
      if (start_ev) begin
        run_next[i]   = 1'b1;
        count_next[i] = reload;
      end else if (stop_ev) begin
        run_next[i] = 1'b0;
      end else if (run_reg[i] && tick[i]) begin
        if (src == START_LFO_NOUF) begin
          // Trimming without underflow measures elapsed ticks, so the count just wraps
          count_next[i] = count_reg[i] - 16'h0001;
        end else if (hit_zero) begin
          uf_next[i] = 1'b1;
          if (ctrl_reg[i][RELOAD_ZERO_BIT]) begin
            count_next[i] = reload;
          end else begin
            count_next[i] = 16'h0000;
            run_next[i]   = 1'b0;
          end
        end else begin
          count_next[i] = count_reg[i] - 16'h0001;
        end
      end
    end
  end

  // Flag: write one clears, a same-cycle underflow wins
  always_comb begin
    flag_next = flag_reg;
    if (wr && idx == FLAG_IDX) begin
      flag_next = flag_reg & ~wbyte[1:0];
    end
    flag_next = flag_next | uf_next;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl_reg[i]   <= CTRL_RESET;
        rel_hi_reg[i] <= RELOAD_RESET;
        rel_lo_reg[i] <= RELOAD_RESET;
        count_reg[i]  <= COUNT_RESET;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        ctrl_reg[i]   <= ctrl_next[i];
        rel_hi_reg[i] <= rel_hi_next[i];
        rel_lo_reg[i] <= rel_lo_next[i];
        count_reg[i]  <= count_next[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg      <= 2'h0;
      uf_reg       <= 2'h0;
      flag_reg     <= 2'h0;
      phase_reg    <= 28'h000_0000;
      slow_cnt_reg <= 6'h00;
    end else begin
      run_reg      <= run_next;
      uf_reg       <= uf_next;
      flag_reg     <= flag_next;
      phase_reg    <= phase_next;
      slow_cnt_reg <= slow_cnt_next;
    end
  end

  // Read data captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      err_reg    <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rdata_mux;
      err_reg    <= !mapped;
    end
  end

endmodule

// File: timer_pair_monitor.sv
`timescale 1ns/1ps
module timer_pair_monitor
  import timer_pair_pkg::*;
(
  // Clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events and status
  input wire logic        tx_done,
  input wire logic        lfo_rise,
  input wire logic [1:0]  second_timer_underflow_flag,
  input wire logic [1:0]  timer_running
);
  wire logic       acc = psel && penable;
  wire logic       run_wr = acc && pwrite && paddr == {RUN_CTRL_IDX, 2'h0}
                            && !tx_done && !lfo_rise;
  wire logic       go = run_wr && pwdata[1] && pwdata[5];
  wire logic [1:0] flg = second_timer_underflow_flag;
  logic            start_reg;
  logic            clr_reg;
  // Causes seen one edge earlier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 1'b0;
      clr_reg   <= 1'b0;
    end else begin
      start_reg <= tx_done || lfo_rise || go;
      clr_reg   <= acc && pwrite && paddr == {FLAG_IDX, 2'h0} && pwdata[1];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_answer_a: assert property (pready == acc)
    else $error("pready differs from select and enable");
  idle_error_a: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access phase");
  misalign_error_a: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access without pslverr");
  run_start_a: assert property (go |=> timer_running[1])
    else $error("run write did not start timer");
  run_stop_a: assert property (run_wr && pwdata[1] && !pwdata[5]
    |=> !timer_running[1]) else $error("run write did not stop timer");
  run_mask_a: assert property (run_wr && !pwdata[1] && !timer_running[1]
    |=> !timer_running[1]) else $error("masked run bit changed");
  run_cause_a: assert property ($rose(timer_running[1]) |-> start_reg)
    else $error("timer started without a start event");
  flag_clear_a: assert property ($fell(flg[1]) |-> clr_reg)
    else $error("underflow flag cleared without write");
  flag_cause_a: assert property ($rose(flg[1]) |-> $past(timer_running[1]))
    else $error("underflow flag set while stopped");
  cover property (go);
  cover property ($rose(flg[1]));
  cover property (pslverr);
endmodule

bind reload_countdown_timer_pair timer_pair_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .tx_done(tx_done), .lfo_rise(lfo_rise),
  .second_timer_underflow_flag(second_timer_underflow_flag),
  .timer_running(timer_running));

// File: test_reload_countdown_timer_pair.sv
`timescale 1ns/1ps
module test_reload_countdown_timer_pair;
  import timer_pair_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00, v;
  logic [1:0]  offs = 2'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic        tx_done = 0, rx_first_bits = 0, lfo_rise = 0, third_uf = 0;
  logic [1:0]  flag, running;
  int          error_cnt = 0, total_checks = 0, seed = 20630;
  int          rel1, cnt1, run1 = 0, flg1 = 0, ctl1;
  logic [5:0]  rw_idx [4] = '{RELOAD0_HI_IDX, RELOAD0_LO_IDX,
                              RELOAD1_HI_IDX, RELOAD1_LO_IDX};
  always #5 pclk = ~pclk;
  reload_countdown_timer_pair dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_done(tx_done), .rx_first_bits(rx_first_bits), .lfo_rise(lfo_rise),
    .third_underflow(third_uf), .second_timer_underflow_flag(flag),
    .timer_running(running));
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Called just after a rising edge; one idle cycle after each transfer
  task apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, offs};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task pulse(input int k);
    case (k)
      0: tx_done <= 1;
      1: rx_first_bits <= 1;
      2: lfo_rise <= 1;
      default: third_uf <= 1;
    endcase
    @(posedge pclk);
    {tx_done, rx_first_bits, lfo_rise, third_uf} <= 4'h0;
    repeat (2) @(posedge pclk);
  endtask
  task ctl(input logic [7:0] c);
    apb(1, CTRL1_IDX, c);
    ctl1 = c;
  endtask
  task start1;
    apb(1, RUN_CTRL_IDX, 8'h22);
    cnt1 = rel1;
    run1 = 1;
  endtask
  // Trim without underflow wraps instead of stopping
  task tick1;
    pulse(3);
    if (run1 != 0 && ctl1[5:4] == 2) cnt1 = (cnt1 + 65535) % 65536;
    else if (run1 != 0 && cnt1 <= 1) begin
      flg1 = 1;
      cnt1 = ctl1[3] ? rel1 : 0;
      run1 = ctl1[3];
    end else if (run1 != 0) cnt1--;
  endtask
  task check1;
    apb(0, COUNT1_HI_IDX, 8'h00);
    chk("count1_hi", 32'(cnt1 >> 8), rd);
    apb(0, COUNT1_LO_IDX, 8'h00);
    chk("count1_lo", 32'(cnt1 & 255), rd);
    chk("running1", 32'(run1), {31'h0, running[1]});
    chk("flag1", 32'(flg1), {31'h0, flag[1]});
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("mismatch watchdog expected done seen hang");
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (rw_idx[i]) begin
      v = 8'($random(seed));
      apb(0, rw_idx[i], 8'h00);
      chk("reset_value", 32'h0, rd);
      apb(1, rw_idx[i], v);
      apb(0, rw_idx[i], 8'h00);
      chk("readback", {24'h0, v}, rd);
    end
    ctl(8'hFF);
    apb(0, CTRL1_IDX, 8'h00);
    chk("ctrl_reserved", 32'h0000_00BB, rd);
    apb(1, COUNT0_LO_IDX, 8'h5A);
    apb(0, COUNT0_LO_IDX, 8'h00);
    chk("count_ro", 32'h0, rd);
    apb(1, 6'h3F, 8'h11);
    chk("unmapped_err", 32'h1, {31'h0, err});
    offs = 2'h2;
    apb(1, CTRL1_IDX, 8'h00);
    chk("misaligned_err", 32'h1, {31'h0, err});
    offs = 2'h0;
    apb(0, CTRL1_IDX, 8'h00);
    chk("misaligned_kept", 32'h0000_00BB, rd);
    ctl(8'h03);
    v = 8'h02 + (8'($random(seed)) & 8'h03);
    apb(1, RELOAD1_HI_IDX, 8'h00);
    apb(1, RELOAD1_LO_IDX, v);
    rel1 = v;
    start1;
    check1;
    apb(1, RELOAD1_LO_IDX, 8'h02);
    rel1 = 2;
    tick1;
    check1;
    while (run1 != 0) tick1;
    check1;
    apb(1, FLAG_IDX, 8'h02);
    flg1 = 0;
    ctl(8'h0B);
    start1;
    repeat (2) tick1;
    check1;
    apb(1, RUN_CTRL_IDX, 8'h20);
    check1;
    apb(1, RUN_CTRL_IDX, 8'h02);
    run1 = 0;
    check1;
    ctl(8'h03);
    pulse(0);
    check1;
    ctl(8'h13);
    pulse(0);
    cnt1 = rel1;
    run1 = 1;
    ctl(8'h93);
    pulse(1);
    run1 = 0;
    check1;
    ctl(8'h13);
    pulse(0);
    run1 = 1;
    pulse(1);
    check1;
    apb(1, RUN_CTRL_IDX, 8'h02);
    run1 = 0;
    apb(1, FLAG_IDX, 8'h02);
    flg1 = 0;
    ctl(8'hA3);
    pulse(2);
    cnt1 = rel1;
    run1 = 1;
    pulse(1);
    repeat (3) tick1;
    check1;
    pulse(2);
    run1 = 0;
    check1;
    apb(1, FLAG_IDX, 8'h03);
    flg1 = 0;
    ctl(8'hB3);
    pulse(2);
    cnt1 = rel1;
    run1 = 1;
    repeat (2) tick1;
    check1;
    apb(1, RELOAD0_HI_IDX, 8'h01);
    apb(1, RELOAD0_LO_IDX, 8'h00);
    apb(1, RUN_CTRL_IDX, 8'h11);
    repeat (100) @(posedge pclk);
    apb(0, COUNT0_HI_IDX, 8'h00);
    chk("count0_hi", 32'h0, rd);
    apb(0, COUNT0_LO_IDX, 8'h00);
    chk("count0_rate", 32'h1, {31'h0, rd >= 240 && rd <= 244});
    chk("running0", 32'h1, {31'h0, running[0]});
    // Remaining count needs about 1800 cycles at the fast tick
    repeat (2500) @(posedge pclk);
    apb(0, COUNT0_LO_IDX, 8'h00);
    chk("count0_end", 32'h0, rd);
    chk("running0_end", 32'h0, {31'h0, running[0]});
    chk("flag0", 32'h1, {31'h0, flag[0]});
    apb(1, FLAG_IDX, 8'h03);
    flg1 = 0;
    ctl(8'h02);
    apb(1, RELOAD0_HI_IDX, 8'h00);
    apb(1, RELOAD0_LO_IDX, 8'h01);
    apb(1, RUN_CTRL_IDX, 8'h33);
    cnt1 = rel1;
    run1 = 1;
    // First timer underflows once and stops; second sees one tick
    repeat (20) @(posedge pclk);
    cnt1--;
    check1;
    chk("flag0_casc", 32'h1, {31'h0, flag[0]});
    apb(1, CTRL0_IDX, 8'h01);
    apb(1, RELOAD0_HI_IDX, 8'h01);
    apb(1, RELOAD0_LO_IDX, 8'h00);
    apb(1, RUN_CTRL_IDX, 8'h11);
    // Slow tick every 64 fast ticks: two or three in this span
    repeat (1200) @(posedge pclk);
    apb(0, COUNT0_LO_IDX, 8'h00);
    chk("count0_slow", 32'h1, {31'h0, rd >= 252 && rd <= 254});
    report_and_stop;
  end
endmodule
